// File: rtl/baud_gen_pkg.sv
package baud_gen_pkg;

    // register byte offsets on the Avalon-MM slave
    localparam logic [3:0] MODE_OFFSET = 4'h0;
    localparam logic [3:0] DIVISOR_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;

    // mode_register field positions
    localparam int SRC_SEL_LSB = 4;
    localparam int SYNC_BIT = 8;
    localparam int OVER8_BIT = 19;

    // status register field positions
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_SCK_IN_BIT = 1;
    localparam int ST_SCK_OUT_BIT = 2;
    localparam int ST_COUNT_LSB = 16;

    // reset values
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;

    // counts
    localparam int DIVISOR_WIDTH = 16;
    localparam int PRESCALE_DIV = 8;
    localparam int OVERSAMPLE_16 = 16;
    localparam int OVERSAMPLE_8 = 8;

    typedef enum logic [1:0] {
        SRC_MAIN = 2'h0,
        SRC_PRESCALED = 2'h1,
        SRC_MAIN_ALT = 2'h2,
        SRC_EXTERNAL = 2'h3
    } clock_source_t;

    typedef struct packed {
        logic oversample_by_8;
        logic synchronous_select;
        clock_source_t clock_source_select;
    } mode_t;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

endpackage : baud_gen_pkg

// File: rtl/tick_divider.sv
module tick_divider #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // source
    input wire logic run,
    input wire logic tick_in,
    input wire logic [W-1:0] ratio,
    // result
    output logic tick_out,
    output logic [W-1:0] count
);

    logic [W-1:0] next_count;
    logic at_end;

    assign at_end = (ratio > W'(1)) && (count >= ratio - W'(1));

    // ratio 0 never fires, ratio 1 passes the source through
    assign tick_out = run && tick_in && ((ratio == W'(1)) || at_end);

    always_comb begin
        next_count = count;
        if (run && tick_in) begin
            if (ratio <= W'(1) || at_end) begin
                next_count = '0;
            end else begin
                next_count = count + W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : tick_divider

// File: rtl/usart_baud_gen.sv
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
module usart_baud_gen #(
    parameter int PRESCALE = baud_gen_pkg::PRESCALE_DIV
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // power manager run permission
    input wire logic run,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // timing strobes
    output logic sample_tick,
    output logic baud_tick
);

    localparam int DW = baud_gen_pkg::DIVISOR_WIDTH;

    // bus slave
    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic [31:0] mode_word;
    logic [31:0] next_mode_word;
    logic [DW-1:0] clock_divisor;
    logic [DW-1:0] next_clock_divisor;
    logic [31:0] wmask;
    logic [31:0] status_word;
    logic wr_take;
    baud_gen_pkg::mode_t mode;

    // pin synchroniser
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    logic sck_rise;

    // generator
    logic src_tick;
    logic pre_tick;
    logic [7:0] pre_cnt;
    logic div_tick;
    logic [DW-1:0] div_cnt;
    logic over_tick;
    logic [4:0] over_cnt;
    logic [4:0] over_ratio;
    // low from a mode write until the next bit tick, which a stale count
    // may bring early
    logic over_settled;
    logic next_over_settled;
    logic async_mode;
    logic main_src;
    logic [DW-1:0] half;
    logic half_hit;
    logic half_q;
    logic next_half_q;

    assign mode = {mode_word[baud_gen_pkg::OVER8_BIT],
        mode_word[baud_gen_pkg::SYNC_BIT],
        mode_word[baud_gen_pkg::SRC_SEL_LSB +: 2]};

    assign waitrequest = (read || write) && !ack;
    assign wr_take = write && ack;
    assign wmask = baud_gen_pkg::lane_mask(byteenable);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[baud_gen_pkg::ST_ACTIVE_BIT] = clock_divisor != '0;
        status_word[baud_gen_pkg::ST_SCK_IN_BIT] = sck_sync;
        status_word[baud_gen_pkg::ST_SCK_OUT_BIT] = sck_out;
        status_word[baud_gen_pkg::ST_COUNT_LSB +: DW] = div_cnt;
    end

    // one wait state per access; writes land while run is low too
    always_comb begin
        next_ack = (read || write) && !ack;
        next_readdata = readdata;
        next_mode_word = mode_word;
        next_clock_divisor = clock_divisor;
        next_over_settled = over_settled || baud_tick;
        if (read && !ack) begin
            unique case (address)
                baud_gen_pkg::MODE_OFFSET: next_readdata = mode_word;
                baud_gen_pkg::DIVISOR_OFFSET:
                    next_readdata = {16'h0000, clock_divisor};
                baud_gen_pkg::STATUS_OFFSET: next_readdata = status_word;
                default: next_readdata = 32'h0000_0000;
            endcase
        end
        if (wr_take) begin
            if (address == baud_gen_pkg::MODE_OFFSET) begin
                next_mode_word = (mode_word & ~wmask) | (writedata & wmask);
                next_over_settled = 1'b0;
            end
            if (address == baud_gen_pkg::DIVISOR_OFFSET) begin
                next_clock_divisor = (clock_divisor & ~wmask[DW-1:0]) |
                    (writedata[DW-1:0] & wmask[DW-1:0]);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack <= 1'b0;
            readdata <= 32'h0000_0000;
            mode_word <= baud_gen_pkg::MODE_RESET;
            clock_divisor <= baud_gen_pkg::DIVISOR_RESET;
            over_settled <= 1'b0;
        end else begin
            ack <= next_ack;
            readdata <= next_readdata;
            mode_word <= next_mode_word;
            clock_divisor <= next_clock_divisor;
            over_settled <= next_over_settled;
        end
    end

    // pin synchroniser and rising-edge detect
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_prev <= 1'b0;
        end else begin
            sck_meta <= sck_in;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
        end
    end
    assign sck_rise = sck_sync && !sck_prev;

    // fixed prescaler on the main clock
    tick_divider #(.W(8)) u_prescale (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(run),
        .tick_in(1'b1),
        .ratio(8'(PRESCALE)),
        .tick_out(pre_tick),
        .count(pre_cnt)
    );

    always_comb begin
        unique case (mode.clock_source_select)
            baud_gen_pkg::SRC_MAIN: src_tick = 1'b1;
            baud_gen_pkg::SRC_PRESCALED: src_tick = pre_tick;
            baud_gen_pkg::SRC_MAIN_ALT: src_tick = 1'b1;
            baud_gen_pkg::SRC_EXTERNAL: src_tick = sck_rise;
        endcase
    end

    // programmable divider; 0 stops it, 1 bypasses it
    tick_divider #(.W(DW)) u_divisor (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(run),
        .tick_in(src_tick),
        .ratio(clock_divisor),
        .tick_out(div_tick),
        .count(div_cnt)
    );

    assign async_mode = !mode.synchronous_select;
    assign over_ratio = mode.oversample_by_8 ?
        5'(baud_gen_pkg::OVERSAMPLE_8) : 5'(baud_gen_pkg::OVERSAMPLE_16);

    tick_divider #(.W(5)) u_oversample (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(run && async_mode),
        .tick_in(div_tick),
        .ratio(over_ratio),
        .tick_out(over_tick),
        .count(over_cnt)
    );

    assign sample_tick = async_mode && div_tick;

    always_comb begin
        if (async_mode) begin
            baud_tick = over_tick;
        end else if (mode.clock_source_select ==
                     baud_gen_pkg::SRC_EXTERNAL) begin
            baud_tick = run && sck_rise;
        end else begin
            baud_tick = div_tick;
        end
    end

    // pin clock: for divisors of 2 or more, high for the first half of each period; with the
    // main clock and an odd divisor the high phase is stretched by half a
    // clock through a falling-edge flop so mark and space match
    assign main_src = mode.clock_source_select == baud_gen_pkg::SRC_MAIN ||
        mode.clock_source_select == baud_gen_pkg::SRC_MAIN_ALT;
    assign half = clock_divisor >> 1;
    assign half_hit = run && main_src && clock_divisor[0] &&
        (div_cnt == half);
    assign next_half_q = half_hit;

    always_ff @(negedge clk_sys) begin
        if (!rst_n) begin
            half_q <= 1'b0;
        end else begin
            half_q <= next_half_q;
        end
    end

    // one expression of the counter, so a count step cannot glitch the pin
    assign sck_out = (clock_divisor != '0) && ((div_cnt < half) ||
        (run && main_src && clock_divisor[0] && div_cnt == half && !half_q));
    assign sck_oe = mode.synchronous_select &&
        mode.clock_source_select != baud_gen_pkg::SRC_EXTERNAL;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence div_write_s;
        wr_take && address == baud_gen_pkg::DIVISOR_OFFSET &&
            byteenable == 4'hf;
    endsequence

    sequence sync_int_write_s;
        wr_take && address == baud_gen_pkg::MODE_OFFSET &&
            byteenable == 4'hf && writedata[baud_gen_pkg::SYNC_BIT] &&
            writedata[baud_gen_pkg::SRC_SEL_LSB +: 2] != 2'h3;
    endsequence

    main_source_a: assert property (
        (run && main_src) |-> src_tick)
        else $error("main clock source not ticking every cycle");

    prescale_a: assert property (
        pre_tick |-> pre_cnt == 8'(PRESCALE - 1))
        else $error("prescaler tick at wrong count");

    div_ratio_a: assert property (
        (div_tick && clock_divisor > 16'h0001 && $stable(clock_divisor)) |->
            div_cnt == clock_divisor - 16'h0001)
        else $error("divider tick at wrong count");

    zero_div_a: assert property (
        (clock_divisor == '0 &&
         !(mode.synchronous_select && !main_src &&
           mode.clock_source_select == baud_gen_pkg::SRC_EXTERNAL)) |->
            !sample_tick && !baud_tick)
        else $error("pulse produced with zero divisor");

    bypass_a: assert property (
        (run && clock_divisor == 16'h0001) |-> div_tick == src_tick)
        else $error("divisor one does not pass source through");

    over_ratio_a: assert property (
        (baud_tick && async_mode && over_settled) |->
            over_cnt == (mode.oversample_by_8 ? 5'h07 : 5'h0f))
        else $error("bit tick at wrong oversample count");

    sync_bit_a: assert property (
        (mode.synchronous_select &&
         mode.clock_source_select != baud_gen_pkg::SRC_EXTERNAL) |->
            baud_tick == div_tick && !sample_tick)
        else $error("sync bit clock not the divided source");

    ext_direct_a: assert property (
        (run && mode.synchronous_select && sck_rise &&
         mode.clock_source_select == baud_gen_pkg::SRC_EXTERNAL) |->
            baud_tick)
        else $error("external pin edge not used as bit clock");

    duty_high_a: assert property (
        (clock_divisor >= 16'h0002 && div_cnt < half) |-> sck_out)
        else $error("pin clock low during first half");

    stopped_write_a: assert property (
        (!run and div_write_s) |=>
            clock_divisor == $past(writedata[DW-1:0]))
        else $error("divisor write lost while stopped");

    hold_state_a: assert property (
        !run |-> !sample_tick && !baud_tick ##1 $stable(div_cnt))
        else $error("generator moved while stopped");

    pin_drive_a: assert property (
        sync_int_write_s |=> sck_oe [*2])
        else $error("pin not driven in sync internal mode");

endmodule : usart_baud_gen

// File: dv/remote_sck_model.sv
module remote_sck_model #(
    parameter int HALF = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // frame control from the bench
    input wire logic enable,
    // clock driven onto the serial clock pin
    output logic sck_drive
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] phase;
    logic [7:0] next_phase;
    logic next_sck_drive;

    // each phase lasts HALF main periods, rate main/(2*HALF)
    always_comb begin
        next_phase = phase;
        next_sck_drive = sck_drive;
        if (!enable) begin
            next_phase = 8'h00;
            next_sck_drive = 1'b0;
        end else if (phase == 8'(HALF - 1)) begin
            next_phase = 8'h00;
            next_sck_drive = !sck_drive;
        end else begin
            next_phase = phase + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase <= 8'h00;
            sck_drive <= 1'b0;
        end else begin
            phase <= next_phase;
            sck_drive <= next_sck_drive;
        end
    end
endmodule : remote_sck_model

// File: dv/usart_baud_rate_generator_tb.sv
module usart_baud_rate_generator_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys, rst_n, run, read, write, sck_in, sck_out, sck_oe;
    logic sample_tick, baud_tick, waitrequest, ext_en, ext_sck;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, q;
    int fail_count, n_tests, cyc, got;
    realtime t0, t1, t2;
    int exp_src[4] = '{2, 16, 2, 6};

    // pin level: design drives while enabled, else the remote side
    assign sck_in = sck_oe ? sck_out : ext_sck;

    usart_baud_gen #(.PRESCALE(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .run(run), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .sample_tick(sample_tick),
        .baud_tick(baud_tick));

    remote_sck_model #(.HALF(3)) remote (.clk_sys(clk_sys), .rst_n(rst_n),
        .enable(ext_en), .sck_drive(ext_sck));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = !clk_sys;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= 4'hf;
        // sampled at each rising edge; only the cycle timeout ends a hang
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0);
        check("bus wait states", 32'd2, 32'(n));
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    function automatic logic [31:0] mode_word(input logic [1:0] src,
                                              input logic sync, over8);
        logic [31:0] w;
        w = 32'h0;
        w[baud_gen_pkg::SRC_SEL_LSB +: 2] = src;
        w[baud_gen_pkg::SYNC_BIT] = sync;
        w[baud_gen_pkg::OVER8_BIT] = over8;
        return w;
    endfunction : mode_word

    // cycles up to the next tick, third interval skips partial ones
    task automatic spacing(input logic sel, output int n);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge clk_sys);
                n++;
            end while ((sel ? baud_tick : sample_tick) !== 1'b1 && n < 999);
        end
    endtask : spacing

    task automatic no_ticks(input string what);
        int c;
        c = 0;
        repeat (64) begin
            @(negedge clk_sys);
            c += int'(sample_tick !== 1'b0) + int'(baud_tick !== 1'b0);
        end
        check(what, 32'h0, 32'(c));
    endtask : no_ticks

    initial begin
        {rst_n, read, write, ext_en, address, byteenable} = '0;
        run = 1'b1;
        writedata = 32'h0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b0, baud_gen_pkg::MODE_OFFSET, 32'h0, q);
        check("mode reset", baud_gen_pkg::MODE_RESET, q);
        bus(1'b0, baud_gen_pkg::DIVISOR_OFFSET, 32'h0, q);
        check("divisor reset", {16'h0, baud_gen_pkg::DIVISOR_RESET}, q);
        wr(4'hc, 32'hffff_ffff);
        bus(1'b0, 4'hc, 32'h0, q);
        check("unmapped", 32'h0, q);
        wr(baud_gen_pkg::DIVISOR_OFFSET, 32'hffff_0007);
        bus(1'b0, baud_gen_pkg::DIVISOR_OFFSET, 32'h0, q);
        check("divisor width", 32'h0000_0007, q);
        $display("test registers done");
        wr(baud_gen_pkg::DIVISOR_OFFSET, 32'h0);
        no_ticks("divisor zero ticks");
        $display("test divisor zero done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_sys);
            ext_en <= (s == 3);
            wr(baud_gen_pkg::MODE_OFFSET, mode_word(2'(s), 1'b0, 1'b0));
            wr(baud_gen_pkg::DIVISOR_OFFSET,
               (s == 3) ? 32'h1 : 32'h2);
            spacing(1'b0, got);
            check("source sample spacing", 32'(exp_src[s]), 32'(got));
        end
        @(posedge clk_sys);
        ext_en <= 1'b0;
        $display("test sources done");
        wr(baud_gen_pkg::MODE_OFFSET, mode_word(2'h0, 1'b0, 1'b0));
        wr(baud_gen_pkg::DIVISOR_OFFSET, 32'h2);
        spacing(1'b1, got);
        check("baud spacing x16", 32'd32, 32'(got));
        wr(baud_gen_pkg::MODE_OFFSET, mode_word(2'h0, 1'b0, 1'b1));
        spacing(1'b1, got);
        check("baud spacing x8", 32'd16, 32'(got));
        wr(baud_gen_pkg::DIVISOR_OFFSET, 32'h1);
        spacing(1'b0, got);
        check("bypass sample spacing", 32'd1, 32'(got));
        $display("test async done");
        wr(baud_gen_pkg::MODE_OFFSET, mode_word(2'h0, 1'b1, 1'b0));
        wr(baud_gen_pkg::DIVISOR_OFFSET, 32'h5);
        spacing(1'b1, got);
        check("sync baud spacing", 32'd5, 32'(got));
        check("sync pin drive", 32'h1, 32'(sck_oe));
        check("sync no sampling", 32'h0, 32'(sample_tick));
        wr(baud_gen_pkg::DIVISOR_OFFSET, 32'h3);
        @(posedge sck_out);
        @(posedge sck_out);
        t0 = $realtime;
        @(negedge sck_out);
        t1 = $realtime;
        @(posedge sck_out);
        t2 = $realtime;
        check("odd high ns", 32'd60, 32'(int'(t1 - t0)));
        check("odd period ns", 32'd120, 32'(int'(t2 - t0)));
        ext_en <= 1'b1;
        wr(baud_gen_pkg::MODE_OFFSET, mode_word(2'h3, 1'b1, 1'b0));
        wr(baud_gen_pkg::DIVISOR_OFFSET, 32'h0);
        spacing(1'b1, got);
        check("pin baud spacing", 32'd6, 32'(got));
        check("pin released", 32'h0, 32'(sck_oe));
        @(posedge clk_sys);
        ext_en <= 1'b0;
        $display("test sync done");
        wr(baud_gen_pkg::MODE_OFFSET, mode_word(2'h0, 1'b0, 1'b0));
        run <= 1'b0;
        wr(baud_gen_pkg::DIVISOR_OFFSET, 32'h4);
        bus(1'b0, baud_gen_pkg::DIVISOR_OFFSET, 32'h0, q);
        check("write while stopped", 32'h4, q);
        bus(1'b0, baud_gen_pkg::STATUS_OFFSET, 32'h0, q);
        check("status active", 32'h1, q & 32'h1);
        no_ticks("stopped ticks");
        @(posedge clk_sys);
        run <= 1'b1;
        spacing(1'b0, got);
        check("resumed spacing", 32'd4, 32'(got));
        $display("test stop done");
        results();
    end
endmodule : usart_baud_rate_generator_tb
